// [design/aorc_map.svh]
`ifndef AORC_MAP_SVH
`define AORC_MAP_SVH

// Register indices; the byte address is four times the index.
`define AORC_IDX_SPK_ROUTE 8'h20
`define AORC_IDX_OUT_ROUTE 8'h21
`define AORC_IDX_STATUS 8'h30

// Reset values of the two routing registers.
`define AORC_RST_SPK_ROUTE 16'h0006
`define AORC_RST_OUT_ROUTE 16'h00E0

// Writable bits; reserved bits read as zero.
`define AORC_MASK_SPK_ROUTE 16'hFFFF
`define AORC_MASK_OUT_ROUTE 16'hFFF8

// Field positions in the speaker routing register.
`define AORC_SPK_DIFF 15
`define AORC_SPK_FIRST_DAC_HI 14
`define AORC_SPK_FIRST_DAC_LO 13
`define AORC_SPK_FIRST_AST 12
`define AORC_SPK_FIRST_BUZ 11
`define AORC_SPK_FIRST_KCL 10
`define AORC_SPK_FIRST_CPI 9
`define AORC_SPK_SECOND_DAC_HI 8
`define AORC_SPK_SECOND_DAC_LO 7
`define AORC_SPK_SECOND_AST 6
`define AORC_SPK_SECOND_BUZ 5
`define AORC_SPK_SECOND_KCL 4
`define AORC_SPK_SECOND_CPI 3
`define AORC_SPK_FIRST_MUTE 2
`define AORC_SPK_SECOND_MUTE 1
`define AORC_SPK_HP_PROTECT_OFF 0

// Field positions in the output routing register.
`define AORC_OUT_MIRROR_LSK 15
`define AORC_OUT_AST_LSK 14
`define AORC_OUT_BUZ_LSK 13
`define AORC_OUT_KCL_LSK 12
`define AORC_OUT_CPI_LSK 11
`define AORC_OUT_MIC_CPO 10
`define AORC_OUT_FIRST_CPO 9
`define AORC_OUT_SECOND_CPO 8
`define AORC_OUT_LSK_MUTE 7
`define AORC_OUT_CPO_MUTE 6
`define AORC_OUT_LSK_PROT_OFF 5
`define AORC_OUT_VIRTUAL_GROUND_DRIVER_PROT_OFF 4
`define AORC_OUT_CAP_SEL 3

`endif

// [design/aorc_pkg.sv]
package aorc_pkg;

  // DAC channel selection carried to each analog destination.
  typedef enum logic [1:0]
  {
    DAC_NONE,
    DAC_LEFT,
    DAC_RIGHT,
    DAC_MIX
  } aorc_dac_e;

  typedef logic [15:0] aorc_word_t;

endpackage : aorc_pkg

// [design/aorc_route.sv]
`timescale 1ns/1ns
`include "aorc_map.svh"

module aorc_route
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [15:0] i_spk_route,
  input wire logic [15:0] i_out_route,
  input wire logic i_first_speaker_pd,
  input wire logic i_earpiece_pd,
  input wire logic i_second_speaker_pd,
  output logic o_mirror_active,
  output logic o_second_to_cell_active,
  output aorc_pkg::aorc_dac_e o_lsk_dac,
  output logic [3:0] o_lsk_src,
  output aorc_pkg::aorc_dac_e o_cpo_dac_first,
  output aorc_pkg::aorc_dac_e o_cpo_dac_second,
  output logic [4:0] o_cpo_src
);

  logic mirror_d;
  logic second_d;
  logic first_cpo;
  aorc_pkg::aorc_dac_e first_dac;
  aorc_pkg::aorc_dac_e second_dac;
  aorc_pkg::aorc_dac_e lsk_dac_d;
  aorc_pkg::aorc_dac_e cpo_first_d;
  aorc_pkg::aorc_dac_e cpo_second_d;
  logic [3:0] lsk_src_d;
  logic [4:0] cpo_src_d;
  logic [3:0] first_src;
  logic [3:0] second_src;

  // Source sets are {sidetone, buzzer, keyclick, cell input}; the cell set adds the microphone.
  always_comb
  begin
    first_dac = aorc_pkg::aorc_dac_e'(
      i_spk_route[`AORC_SPK_FIRST_DAC_HI:`AORC_SPK_FIRST_DAC_LO]);
    second_dac = aorc_pkg::aorc_dac_e'(
      i_spk_route[`AORC_SPK_SECOND_DAC_HI:`AORC_SPK_SECOND_DAC_LO]);
    first_src = i_spk_route[`AORC_SPK_FIRST_AST:`AORC_SPK_FIRST_CPI];
    second_src = i_spk_route[`AORC_SPK_SECOND_AST:`AORC_SPK_SECOND_CPI];
    // Mirroring only takes hold with all three speaker drivers powered down.
    mirror_d = i_out_route[`AORC_OUT_MIRROR_LSK] & i_first_speaker_pd & i_earpiece_pd
      & i_second_speaker_pd;
    lsk_dac_d = mirror_d ? first_dac : aorc_pkg::DAC_NONE;
    lsk_src_d = i_out_route[`AORC_OUT_AST_LSK:`AORC_OUT_CPI_LSK]
      | (mirror_d ? first_src : 4'h0);
    // First speaker mirror to cell output ignores driver power state.
    first_cpo = i_out_route[`AORC_OUT_FIRST_CPO];
    // Second speaker mirror needs single-ended mode and no loudspeaker mirror.
    second_d = i_out_route[`AORC_OUT_SECOND_CPO] & ~i_spk_route[`AORC_SPK_DIFF]
      & ~mirror_d;
    cpo_first_d = first_cpo ? first_dac : aorc_pkg::DAC_NONE;
    cpo_second_d = second_d ? second_dac : aorc_pkg::DAC_NONE;
    cpo_src_d[4:1] = (first_cpo ? {first_src[3:1], 1'b0} : 4'h0)
      | (second_d ? second_src : 4'h0);
    cpo_src_d[0] = i_out_route[`AORC_OUT_MIC_CPO];
  end

  // Routing controls are registered so the analog side sees clean levels.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_mirror_active <= 1'b0;
      o_second_to_cell_active <= 1'b0;
      o_lsk_dac <= aorc_pkg::DAC_NONE;
      o_lsk_src <= 4'h0;
      o_cpo_dac_first <= aorc_pkg::DAC_NONE;
      o_cpo_dac_second <= aorc_pkg::DAC_NONE;
      o_cpo_src <= 5'h00;
    end
    else
    begin
      o_mirror_active <= mirror_d;
      o_second_to_cell_active <= second_d;
      o_lsk_dac <= lsk_dac_d;
      o_lsk_src <= lsk_src_d;
      o_cpo_dac_first <= cpo_first_d;
      o_cpo_dac_second <= cpo_second_d;
      o_cpo_src <= cpo_src_d;
    end
  end

endmodule : aorc_route

// [design/aorc_top.sv]
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "aorc_map.svh"

// Operation
// - Mirror bit copies first speaker routing onto the loudspeaker pair once all three speaker drivers are powered down.
// - Bit 14 routes analog sidetone to the loudspeaker; resets to 0.
// - Bit 13 routes the buzzer gain stage to the loudspeaker; resets to 0.
// - Bit 12 routes keyclick to the loudspeaker; resets to 0.
// - Bit 11 routes cell-phone input to the loudspeaker; resets to 0.
// - Bit 10 routes the selected microphone to the cell output; resets to 0.
// - Bit 9 copies first speaker sources, except cell input, to cell output.
// - Bit 8 copies second speaker sources to cell output, single-ended, unmirrored.
// - Bit 7 mutes the loudspeaker; resets to 1.
// - Bit 6 mutes the cell output; resets to 1.
// - Bit 5 high disables loudspeaker short protection; resets to 1.
// - Bit 4 high disables virtual ground short protection; resets to 0.
// - Bit 3 selects capacitor-coupled headset when 1, capless when 0.
// - Bits 2 to 0 are reserved, read zero, written as zero.
// - Neighbour register bit 15 selects differential over single-ended speaker output.

module aorc_top
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_first_speaker_pd,
  input wire logic i_earpiece_pd,
  input wire logic i_second_speaker_pd,
  output logic o_differential_output_select,
  output logic o_first_speaker_mute,
  output logic o_second_speaker_mute,
  output logic o_headphone_short_protect_en,
  output logic o_mirror_active,
  output aorc_pkg::aorc_dac_e o_lsk_dac,
  output logic o_sidetone_to_loudspeaker,
  output logic o_buzzer_to_loudspeaker,
  output logic o_keyclick_to_loudspeaker,
  output logic o_cell_input_to_loudspeaker,
  output logic o_loudspeaker_mute,
  output logic o_loudspeaker_short_protect_en,
  output logic o_virtual_ground_short_protect_en,
  output logic o_headset_cap_coupled,
  output aorc_pkg::aorc_dac_e o_cpo_dac_first,
  output aorc_pkg::aorc_dac_e o_cpo_dac_second,
  output logic o_cpo_sidetone,
  output logic o_cpo_buzzer,
  output logic o_cpo_keyclick,
  output logic o_cpo_cell_input,
  output logic o_mic_to_cell_output,
  output logic o_cell_output_mute
);

  // True when a byte address is word aligned and lands on a register index.
  function automatic logic aorc_hit(input logic [7:0] addr, input logic [7:0] idx);
    aorc_hit = (addr[1:0] == 2'h0) && ({2'h0, addr[7:2]} == idx);
  endfunction : aorc_hit

  aorc_pkg::aorc_word_t spk_route_q;
  aorc_pkg::aorc_word_t spk_route_d;
  aorc_pkg::aorc_word_t out_route_q;
  aorc_pkg::aorc_word_t out_route_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic access;
  logic complete;
  logic done_q;
  logic done_d;
  logic hit_spk;
  logic hit_out;
  logic hit_status;
  logic second_to_cell_active;
  logic [3:0] lsk_src;
  logic [4:0] cpo_src;
  logic [15:0] status_word;
  logic [15:0] spk_read;

  // One wait state lets read data and the error flag come from flops yet stand at completion.
  assign o_pready = done_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

  // Address decode for the access phase.
  always_comb
  begin
    access = i_psel & i_penable;
    complete = access & done_q;
    done_d = access & ~done_q;
    hit_spk = aorc_hit(i_paddr, `AORC_IDX_SPK_ROUTE);
    hit_out = aorc_hit(i_paddr, `AORC_IDX_OUT_ROUTE);
    hit_status = aorc_hit(i_paddr, `AORC_IDX_STATUS);
  end

  // Status shows the routing actually in force and the driver power state.
  always_comb
  begin
    status_word = 16'h0000;
    status_word[0] = o_mirror_active;
    status_word[1] = second_to_cell_active;
    status_word[2] = i_first_speaker_pd;
    status_word[3] = i_earpiece_pd;
    status_word[4] = i_second_speaker_pd;
  end

  // The headphone protection bit is write-only, so it reads back as zero.
  always_comb
  begin
    spk_read = spk_route_q;
    spk_read[`AORC_SPK_HP_PROTECT_OFF] = 1'b0;
  end

  // Register writes land whole at the completing edge; reserved bits stay zero.
  always_comb
  begin
    spk_route_d = spk_route_q;
    out_route_d = out_route_q;
    if (complete && i_pwrite && hit_spk)
    begin
      spk_route_d = i_pwdata[15:0] & `AORC_MASK_SPK_ROUTE;
    end
    if (complete && i_pwrite && hit_out)
    begin
      out_route_d = i_pwdata[15:0] & `AORC_MASK_OUT_ROUTE;
    end
  end

  // Read data and error flag are loaded in the wait cycle and stand at completion.
  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (access && !done_q)
    begin
      prdata_d = 32'h0000_0000;
      if (hit_spk)
      begin
        prdata_d = {16'h0000, spk_read};
      end
      else if (hit_out)
      begin
        prdata_d = {16'h0000, out_route_q};
      end
      else if (hit_status)
      begin
        prdata_d = {16'h0000, status_word};
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
  end

  // Register state; read data is held so the master may sample it late.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      spk_route_q <= `AORC_RST_SPK_ROUTE;
      out_route_q <= `AORC_RST_OUT_ROUTE;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      spk_route_q <= spk_route_d;
      out_route_q <= out_route_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // The read flop keeps its value between transfers, avoiding a toggling bus.

  // Source routing for both destinations.
  aorc_route u_route
  (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_spk_route(spk_route_q),
    .i_out_route(out_route_q),
    .i_first_speaker_pd(i_first_speaker_pd),
    .i_earpiece_pd(i_earpiece_pd),
    .i_second_speaker_pd(i_second_speaker_pd),
    .o_mirror_active(o_mirror_active),
    .o_second_to_cell_active(second_to_cell_active),
    .o_lsk_dac(o_lsk_dac),
    .o_lsk_src(lsk_src),
    .o_cpo_dac_first(o_cpo_dac_first),
    .o_cpo_dac_second(o_cpo_dac_second),
    .o_cpo_src(cpo_src)
  );

  // Loudspeaker source enables.
  assign o_sidetone_to_loudspeaker = lsk_src[3];
  assign o_buzzer_to_loudspeaker = lsk_src[2];
  assign o_keyclick_to_loudspeaker = lsk_src[1];
  assign o_cell_input_to_loudspeaker = lsk_src[0];

  // Cell output source enables.
  assign o_cpo_sidetone = cpo_src[4];
  assign o_cpo_buzzer = cpo_src[3];
  assign o_cpo_keyclick = cpo_src[2];
  assign o_cpo_cell_input = cpo_src[1];
  assign o_mic_to_cell_output = cpo_src[0];

  // Plain control fields come straight from the register flops.
  // Protection enables are active high here, the inverse of the stored bits.
  assign o_loudspeaker_mute = out_route_q[`AORC_OUT_LSK_MUTE];
  assign o_cell_output_mute = out_route_q[`AORC_OUT_CPO_MUTE];
  assign o_loudspeaker_short_protect_en = ~out_route_q[`AORC_OUT_LSK_PROT_OFF];
  assign o_virtual_ground_short_protect_en = ~out_route_q[`AORC_OUT_VIRTUAL_GROUND_DRIVER_PROT_OFF];
  assign o_headset_cap_coupled = out_route_q[`AORC_OUT_CAP_SEL];

  // Neighbour register controls that leave the block directly.
  assign o_differential_output_select = spk_route_q[`AORC_SPK_DIFF];
  assign o_first_speaker_mute = spk_route_q[`AORC_SPK_FIRST_MUTE];
  assign o_second_speaker_mute = spk_route_q[`AORC_SPK_SECOND_MUTE];
  assign o_headphone_short_protect_en = ~spk_route_q[`AORC_SPK_HP_PROTECT_OFF];

endmodule : aorc_top

// [tb/aorc_top_monitor.sv]
`timescale 1ns/1ns

module aorc_top_monitor
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_first_speaker_pd,
  input wire logic i_earpiece_pd,
  input wire logic i_second_speaker_pd,
  input wire logic o_mirror_active,
  input wire aorc_pkg::aorc_dac_e o_lsk_dac,
  input wire logic o_loudspeaker_mute,
  input wire logic o_cell_output_mute,
  input wire logic o_loudspeaker_short_protect_en,
  input wire logic o_virtual_ground_short_protect_en,
  input wire logic o_headset_cap_coupled,
  input wire logic o_cpo_cell_input
);
  logic acc;
  logic wr_out;
  logic unmapped;

  // Completed accesses; pslverr is judged against the address decode.
  assign acc = i_psel && i_penable && o_pready;
  assign wr_out = acc && i_pwrite && (i_paddr == 8'h84);
  assign unmapped = !(i_paddr inside {8'h80, 8'h84, 8'hC0});

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  lsk_mute_a: assert property (wr_out |=> o_loudspeaker_mute == $past(i_pwdata[7]))
    else $error("loudspeaker mute wrong after write");
  cpo_mute_a: assert property (wr_out |=> o_cell_output_mute == $past(i_pwdata[6]))
    else $error("cell output mute wrong after write");
  lsk_prot_a: assert property (wr_out |=> o_loudspeaker_short_protect_en != $past(i_pwdata[5]))
    else $error("loudspeaker protection wrong after write");
  virtual_ground_driver_prot_a: assert property (wr_out |=> o_virtual_ground_short_protect_en != $past(i_pwdata[4]))
    else $error("virtual ground protection wrong after write");
  cap_sel_a: assert property (wr_out |=> o_headset_cap_coupled == $past(i_pwdata[3]))
    else $error("headset coupling wrong after write");
  rsv_read_a: assert property (acc && !i_pwrite && i_paddr == 8'h84 |->
    o_prdata[2:0] == 3'h0 && o_prdata[31:16] == 16'h0000) else $error("reserved bits read nonzero");
  mirror_gate_a: assert property (o_mirror_active |->
    $past(i_first_speaker_pd && i_earpiece_pd && i_second_speaker_pd)) else $error("mirror ungated");
  mirror_dac_a: assert property (!o_mirror_active |-> o_lsk_dac == aorc_pkg::DAC_NONE)
    else $error("loudspeaker DAC routed without mirror");
  cell_gate_a: assert property (o_cpo_cell_input |-> !o_mirror_active)
    else $error("second speaker copy active while mirrored");
  slverr_map_a: assert property (acc |-> o_pslverr == unmapped)
    else $error("error response does not follow address decode");
  reset_mute_a: assert property (disable iff (1'b0) !i_resetn |=>
    o_loudspeaker_mute && o_cell_output_mute && !o_mirror_active) else $error("reset state wrong");
endmodule : aorc_top_monitor

bind aorc_top aorc_top_monitor mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_lsk_dac(o_lsk_dac),
  .i_first_speaker_pd(i_first_speaker_pd), .i_earpiece_pd(i_earpiece_pd),
  .i_second_speaker_pd(i_second_speaker_pd), .o_mirror_active(o_mirror_active),
  .o_loudspeaker_mute(o_loudspeaker_mute), .o_cell_output_mute(o_cell_output_mute),
  .o_loudspeaker_short_protect_en(o_loudspeaker_short_protect_en),
  .o_virtual_ground_short_protect_en(o_virtual_ground_short_protect_en),
  .o_headset_cap_coupled(o_headset_cap_coupled), .o_cpo_cell_input(o_cpo_cell_input));

// [tb/tb_audio_output_routing_control.sv]
`timescale 1ns/1ns

module tb_audio_output_routing_control;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0] pd = 3'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  logic [31:0] r32;
  logic [8:0] dir;
  logic [15:0] obs;
  logic [15:0] om;
  int n_fail = 0;
  int checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  aorc_top uut (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_first_speaker_pd(pd[2]), .i_earpiece_pd(pd[1]),
    .i_second_speaker_pd(pd[0]), .o_differential_output_select(dir[8]),
    .o_first_speaker_mute(dir[7]), .o_second_speaker_mute(dir[6]),
    .o_headphone_short_protect_en(dir[5]), .o_mirror_active(obs[15]), .o_lsk_dac(obs[14:13]),
    .o_sidetone_to_loudspeaker(obs[12]), .o_buzzer_to_loudspeaker(obs[11]),
    .o_keyclick_to_loudspeaker(obs[10]), .o_cell_input_to_loudspeaker(obs[9]),
    .o_loudspeaker_mute(dir[4]), .o_loudspeaker_short_protect_en(dir[2]),
    .o_virtual_ground_short_protect_en(dir[1]), .o_headset_cap_coupled(dir[0]),
    .o_cpo_dac_first(obs[8:7]), .o_cpo_dac_second(obs[6:5]), .o_cpo_sidetone(obs[4]),
    .o_cpo_buzzer(obs[3]), .o_cpo_keyclick(obs[2]), .o_cpo_cell_input(obs[1]),
    .o_mic_to_cell_output(obs[0]), .o_cell_output_mute(dir[3]));

  // Expected routing outputs; mirroring needs all three drivers powered down.
  function automatic logic [15:0] exp_vec(input logic [15:0] s, input logic [15:0] o,
    input logic [2:0] p);
    logic m;
    logic e8;
    m = o[15] & (&p);
    e8 = o[8] & ~s[15] & ~m;
    exp_vec = {m, m ? s[14:13] : 2'h0, o[14] | (m & s[12]), o[13] | (m & s[11]),
      o[12] | (m & s[10]), o[11] | (m & s[9]), o[9] ? s[14:13] : 2'h0,
      e8 ? s[8:7] : 2'h0, (o[9] & s[12]) | (e8 & s[6]), (o[9] & s[11]) | (e8 & s[5]),
      (o[9] & s[10]) | (e8 & s[4]), e8 & s[3], o[10]};
  endfunction : exp_vec

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; ready, read data and error are sampled while they stand before each edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(negedge clk);
      ok = pready;
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      n++;
    end
    while (ok !== 1'b1 && n < 50);
    if (ok !== 1'b1)
      n_fail++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Reads both registers back, then compares every routing and control output.
  task automatic chk_all(input logic [15:0] s, input logic [15:0] o, input logic [2:0] p);
    apb(1'b0, 8'h84, 32'h0);
    chk(rd, {16'h0000, o & 16'hFFF8});
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, {16'h0000, s & 16'hFFFE});
    chk(obs, exp_vec(s, o, p));
    chk(dir, {s[15], s[2], s[1], ~s[0], o[7], o[6], ~o[5], ~o[4], o[3]});
  endtask : chk_all

  // Software writes zeros to reserved bits and mirrors only with all drivers down.
  task automatic run(input logic [15:0] s, input logic [15:0] o, input logic [2:0] p);
    om = o & 16'hFFF8;
    if (!(&p))
      om[15] = 1'b0;
    @(posedge clk);
    pd <= p;
    apb(1'b1, 8'h80, {16'hA5A5, s});
    apb(1'b1, 8'h84, {16'h5A5A, om});
    chk_all(s, om, p);
  endtask : run

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Guard against a hung handshake.
  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end

  initial
  begin
    void'($urandom(79));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk_all(16'h0006, 16'h00E0, 3'h0);
    $display("test reset values done");
    run(16'hFFFF, 16'hFFFF, 3'h7);
    run(16'h7FF8, 16'hFF07, 3'h3);
    run(16'h0000, 16'h0000, 3'h7);
    $display("test corner routing done");
    repeat (40)
    begin
      r32 = $urandom;
      run(r32[15:0], r32[31:16], r32[2:0] | {3{r32[5]}});
    end
    $display("test random routing done");
    apb(1'b1, 8'h88, 32'h0000FFFF);
    chk(err, 1'b1);
    apb(1'b1, 8'h85, 32'h0000FFFF);
    chk(err, 1'b1);
    chk_all(r32[15:0], om, r32[2:0] | {3{r32[5]}});
    $display("test unmapped access done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    pd <= 3'h0;
    chk_all(16'h0006, 16'h00E0, 3'h0);
    $display("test second reset done");
    test_done();
  end
endmodule : tb_audio_output_routing_control
